// ---- dv/emc_core_tb_top.sv ----
// Purpose: Bench for reset hold, power commands, totals and channel pick
// Assumes: host model performs all bus cycles
// Notes:   short master reset count for simulation
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_total++; \
   $display("Error t=%0t got=%0h exp=%0h", $time, a, b); end end
module emc_core_tb_top;
   import emc_pkg::*;
   logic clk_i = 0, rst_i = 1, pa = 1, pd = 0, mrst, zv, zi, csel;
   int err_total = 0, total_checks = 0;
   emc_wb_req_t req;
   emc_wb_rsp_t rsp;
   emc_samples_t smp = '0;
   emc_lowrate_t lr = '0;
   emc_power_t pwr;
   emc_totals_t tot;
   logic [23:0] fr, va, vr;
   emc_core #(.MASTER_RST_CYCLES(20)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .por_fine_analog_i(pa),
      .por_fine_digital_i(pd), .wb_req_i(req), .wb_rsp_o(rsp), .samples_i(smp), .lowrate_i(lr),
      .master_rst_o(mrst), .power_o(pwr), .zx_voltage_o(zv), .zx_current_o(zi), .freq_ratio_o(fr),
      .chan_sel_o(csel), .totals_o(tot), .v_active_o(va), .v_reactive_o(vr));
   emc_host_model bus_u (.clk_i(clk_i), .rsp_i(rsp), .req_o(req));
   initial begin
      forever #20 clk_i = ~clk_i;
   end
   task automatic lowrate(input logic [31:0] p1, input logic [31:0] p2);
      @(posedge clk_i);
      lr <= '{done: 1'b1, ch1: '{p1, p1, p1, 24'h0}, ch2: '{p2, p2, p2, 24'h0}};
      @(posedge clk_i);
      lr.done <= 1'b0;
      repeat (2) @(posedge clk_i);
   endtask : lowrate
   task automatic tick(input logic [23:0] v);
      @(posedge clk_i);
      smp.tick <= 1'b1;
      smp.v <= v;
      smp.i1 <= v;
      @(posedge clk_i);
      smp.tick <= 1'b0;
   endtask : tick
   task automatic final_report();
      err_total += bus_u.to_cnt;
      $display("checks=%0d errors=%0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : final_report
   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (25) @(posedge clk_i);
      `CHK(mrst, 1'b1)
      pd <= 1'b1;
      repeat (18) @(posedge clk_i);
      `CHK(mrst, 1'b1)
      repeat (4) @(posedge clk_i);
      `CHK(mrst, 1'b0)
      pa <= 1'b0;
      repeat (3) @(posedge clk_i);
      `CHK(mrst, 1'b1)
      pa <= 1'b1;
      bus_u.xfer(1'b0, OFS_CROSS_COUNT, 32'h0);
      `CHK(bus_u.rd_q[15:0], RST_CROSS_COUNT)
      bus_u.xfer(1'b0, OFS_FREQ_RATIO, 32'h0);
      `CHK(bus_u.rd_q[23:0], RST_FREQ_RATIO)
      `CHK(fr, RST_FREQ_RATIO)
      bus_u.xfer(1'b0, 8'hFC, 32'h0);
      `CHK(bus_u.rd_q, 32'h0)
      bus_u.xfer(1'b1, OFS_COMMAND, CMD_STANDBY);
      repeat (2) @(posedge clk_i);
      `CHK(pwr, 6'h3E)
      bus_u.xfer(1'b0, OFS_PRIMARY_STATUS, 32'h0);
      `CHK(bus_u.rd_q[STAT_DATA_READY_FLAG_BIT], 1'b1)
      bus_u.xfer(1'b1, OFS_PRIMARY_STATUS, 32'h1);
      bus_u.xfer(1'b1, OFS_COMMAND, CMD_WAKEUP);
      repeat (2) @(posedge clk_i);
      `CHK(pwr, 6'h01)
      bus_u.xfer(1'b0, OFS_PRIMARY_STATUS, 32'h0);
      `CHK(bus_u.rd_q[STAT_DATA_READY_FLAG_BIT], 1'b1)
      bus_u.xfer(1'b1, OFS_SECOND_CFG, 32'h01);
      lowrate(32'h100, 32'h300);
      `CHK(tot, {3{32'h200}})
      bus_u.xfer(1'b1, OFS_SECOND_CFG, 32'h60);
      lowrate(32'h100, 32'h300);
      `CHK(tot, {3{32'h300}})
      bus_u.xfer(1'b1, OFS_MIN_SWITCH, 32'h0);
      bus_u.xfer(1'b1, OFS_SECOND_CFG, 32'h00);
      lowrate(32'h3F2, 32'h3E8);
      `CHK(tot, {3{32'h3E8}})
      lowrate(32'h7D0, 32'h3E8);
      `CHK({csel, tot}, {1'b0, {3{32'h7D0}}})
      bus_u.xfer(1'b1, OFS_MIN_SWITCH, 32'h1388);
      lowrate(32'h7D0, 32'hBB8);
      `CHK({csel, tot}, {1'b0, {3{32'h7D0}}})
      smp.v_rms <= 24'h123456;
      bus_u.xfer(1'b1, OFS_SECOND_CFG, 32'h80);
      repeat (2) @(posedge clk_i);
      `CHK(va, RST_FIXED_VOLT)
      `CHK(vr, 24'h123456)
      smp.v_peak <= 24'h100000;
      smp.i1_peak <= 24'h100000;
      tick(24'h800000);
      @(posedge clk_i);
      `CHK({zv, zi}, 2'b11)
      bus_u.xfer(1'b1, OFS_VZX_THRESH, 32'h200000);
      tick(24'h100000);
      @(posedge clk_i);
      `CHK(zv, 1'b0)
      smp.v_peak <= 24'h300000;
      bus_u.xfer(1'b1, OFS_CROSS_COUNT, 32'h2);
      bus_u.xfer(1'b1, OFS_SECOND_CFG, 32'h08);
      for (int k = 0; k < 5; k++) tick((k % 4) < 2 ? 24'h800000 : 24'h100000);
      repeat (30) @(posedge clk_i);
      `CHK(fr, 24'h400000)
      bus_u.xfer(1'b0, OFS_PRIMARY_STATUS, 32'h0);
      `CHK(bus_u.rd_q[STAT_FUP_BIT], 1'b1)
      final_report();
   end
endmodule : emc_core_tb_top
`default_nettype wire

// ---- dv/emc_host_model.sv ----
// Purpose: Host model issuing classic Wishbone cycles
// Assumes: one access at a time, full word lanes
// Notes:   missing ack after 20 cycles counts in to_cnt
`timescale 1ns/1ps
`default_nettype none
module emc_host_model (
   input wire logic clk_i,
   input wire emc_pkg::emc_wb_rsp_t rsp_i,
   output var emc_pkg::emc_wb_req_t req_o
);
   import emc_pkg::*;
   int to_cnt = 0;
   logic [31:0] rd_q;
   initial req_o = '0;
   task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
      int n;
      n = 0;
      @(posedge clk_i);
      req_o <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: dat};
      do begin
         @(posedge clk_i);
         n++;
      end while (rsp_i.ack !== 1'b1 && n < 20);
      if (rsp_i.ack !== 1'b1) to_cnt++;
      rd_q = rsp_i.dat;
      req_o <= '0;
   endtask : xfer
endmodule : emc_host_model
`default_nettype wire

// ---- logic/emc_core.sv ----
// Purpose: Energy meter channel control: reset hold, power modes, zero crossing, frequency, totals
// Assumes: Samples and low-rate results arrive synchronous to clk_i; one Wishbone classic master
// Notes:   Every register answers with ack one cycle after the request edge
//
// Overview of operation
// [RULE1] Master reset stays asserted 130 ms after power-on indication becomes good.
// [RULE2] Power-on indication is analog fine detector AND digital fine detector.
// [RULE3] Standby powers down converters, rough buffer, temperature sensor; stops system time.
// [RULE4] Wake-up clears converter power-downs and restarts system time.
// [RULE5] Finished standby or wake-up sets the data-ready flag.
// [RULE6] Crossings use voltage and one current channel chosen by a config bit.
// [RULE7] Optional 80 Hz low-pass filter ahead of crossing detection.
// [RULE8] Crossings only count while channel peak exceeds its own threshold.
// [RULE9] Frequency measurement runs only while automatic calculation bit is set.
// [RULE10] Measurement spans programmable crossing count, default 100.
// [RULE11] Each result updates frequency ratio and sets frequency-update flag.
// [RULE12] Results are only valid for 40 Hz to 75 Hz line frequency.
// [RULE13] Frequency ratio is line frequency over word rate, default 0.0125, drives quadrature gain.
// [RULE14] Mode 01 totals are half the sum of both channel results.
// [RULE15] Mode 00 totals copy the selected current channel's results.
// [RULE16] Automatic pick uses larger active power or RMS current per basis bit.
// [RULE17] Automatic switching only while one channel exceeds the minimum amplitude.
// [RULE18] Switch only when other channel exceeds active times channel level.
// [RULE19] Hold bit stops automatic selection; force bit then picks the channel.
// [RULE20] Fixed-voltage bit substitutes programmable RMS voltage, default 0.707107.
// [RULE21] Fixed voltage feeds only active power paths, never reactive.
// [RULE22] Totals and selection are re-evaluated once per low-rate interval.
//
// Local design decisions: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module emc_core #(
   parameter int unsigned MASTER_RST_CYCLES = emc_pkg::RST_HOLD_CYCLES
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic por_fine_analog_i,
   input wire logic por_fine_digital_i,
   input wire emc_pkg::emc_wb_req_t wb_req_i,
   output emc_pkg::emc_wb_rsp_t wb_rsp_o,
   input wire emc_pkg::emc_samples_t samples_i,
   input wire emc_pkg::emc_lowrate_t lowrate_i,
   output logic master_rst_o,
   output emc_pkg::emc_power_t power_o,
   output logic zx_voltage_o,
   output logic zx_current_o,
   output logic [23:0] freq_ratio_o,
   output logic chan_sel_o,
   output emc_pkg::emc_totals_t totals_o,
   output logic [23:0] v_active_o,
   output logic [23:0] v_reactive_o
);
   import emc_pkg::*;

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [22:0] rst_cnt; logic mrst;
      emc_pwr_t pwr; logic [2:0] adc_pd; logic buf_pd; logic temp_pd;
      logic cfg0_izx; logic [7:0] cfg2; logic data_ready_flag; logic freq_update_flag;
      logic [23:0] vzx_th; logic [23:0] izx_th; logic [15:0] crossing_count_setting; logic [23:0] eps;
      logic [31:0] min_amp; logic [23:0] lvl; logic [23:0] fixed_voltage_enable_val;
      logic [23:0] v_f; logic [23:0] i_f; logic v_sgn; logic i_sgn; logic zx_v; logic zx_i;
      logic armed; logic [15:0] zx_cnt; logic [31:0] ticks;
      logic busy; logic [4:0] step; logic [32:0] rem; logic [31:0] den; logic [23:0] quo;
      logic chan; emc_totals_t tot; logic [23:0] v_act; logic [23:0] v_react;
      logic ack; logic [31:0] rdat;
   } emc_state_t;

   localparam logic [22:0] HOLD_M1 = 23'(MASTER_RST_CYCLES - 1);

   emc_state_t s_q;
   emc_state_t s_d;

   function automatic logic [31:0] emc_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
      return r;
   endfunction : emc_merge

   function automatic logic [31:0] emc_half_sum(input logic [31:0] a, input logic [31:0] b);
      logic [32:0] s;
      s = {a[31], a} + {b[31], b};
      return s[32:1];
   endfunction : emc_half_sum

   function automatic logic [31:0] emc_abs(input logic [31:0] a);
      return a[31] ? 32'(-a) : a;
   endfunction : emc_abs

   logic por_good;
   logic wb_hit;
   logic wb_wr;
   logic [31:0] wdat;
   logic [31:0] rmux;
   logic [24:0] v_lp, i_lp;
   logic [23:0] i_smp;
   logic [23:0] i_pk;
   logic [23:0] v_det, i_det;
   logic v_cross, i_cross;
   logic [32:0] rem2;
   logic [31:0] m1, m2;
   logic [55:0] act_scaled, oth_scaled;
   logic run;

   assign por_good = por_fine_analog_i & por_fine_digital_i;  // [RULE2]
   assign run = (s_q.pwr == EMC_RUN);
   assign wb_hit = wb_req_i.cyc & wb_req_i.stb & ~s_q.ack;
   assign wb_wr = wb_req_i.cyc & wb_req_i.stb & wb_req_i.we & s_q.ack;

   // ---------------------------------------------------------------
   // Read mux
   // ---------------------------------------------------------------
   always_comb begin
      rmux = 32'h00000000;
      unique case (wb_req_i.adr)
         OFS_FIRST_CFG: rmux[CFG0_IZX_BIT] = s_q.cfg0_izx;
         OFS_SECOND_CFG: rmux[7:0] = s_q.cfg2;
         OFS_PRIMARY_STATUS: begin
            rmux[STAT_DATA_READY_FLAG_BIT] = s_q.data_ready_flag;
            rmux[STAT_FUP_BIT] = s_q.freq_update_flag;
            rmux[STAT_CHAN_BIT] = s_q.chan;
            rmux[STAT_STBY_BIT] = ~run;
         end
         OFS_VZX_THRESH: rmux[23:0] = s_q.vzx_th;
         OFS_IZX_THRESH: rmux[23:0] = s_q.izx_th;
         OFS_CROSS_COUNT: rmux[15:0] = s_q.crossing_count_setting;
         OFS_FREQ_RATIO: rmux[23:0] = s_q.eps;
         OFS_MIN_SWITCH: rmux = s_q.min_amp;
         OFS_CHAN_LEVEL: rmux[23:0] = s_q.lvl;
         OFS_FIXED_VOLT: rmux[23:0] = s_q.fixed_voltage_enable_val;
         OFS_P_TOTAL: rmux = s_q.tot.p;
         OFS_Q_TOTAL: rmux = s_q.tot.q;
         OFS_S_TOTAL: rmux = s_q.tot.s;
         default: rmux = 32'h00000000;
      endcase
   end

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      wdat = 32'h00000000;
      rem2 = 33'h000000000;
      s_d.ack = wb_hit;
      s_d.rdat = wb_hit ? rmux : s_q.rdat;
      s_d.zx_v = 1'b0;
      s_d.zx_i = 1'b0;

      // Master reset hold
      if (!por_good) begin
         s_d.rst_cnt = '0;
         s_d.mrst = 1'b1;
      end else if (s_q.mrst) begin
         if (s_q.rst_cnt == HOLD_M1) begin
            s_d.mrst = 1'b0;  // [RULE1]
         end else begin
            s_d.rst_cnt = s_q.rst_cnt + 23'h000001;  // [RULE1]
         end
      end

      // Register writes
      if (wb_wr) begin
         unique case (wb_req_i.adr)
            OFS_FIRST_CFG: begin
               wdat = emc_merge({31'h0, s_q.cfg0_izx}, wb_req_i.dat, wb_req_i.sel);
               s_d.cfg0_izx = wdat[CFG0_IZX_BIT];
            end
            OFS_SECOND_CFG: begin
               wdat = emc_merge({24'h0, s_q.cfg2}, wb_req_i.dat, wb_req_i.sel);
               s_d.cfg2 = wdat[7:0];
            end
            OFS_PRIMARY_STATUS: begin
               if (wb_req_i.sel[0] && wb_req_i.dat[STAT_DATA_READY_FLAG_BIT]) s_d.data_ready_flag = 1'b0;
               if (wb_req_i.sel[0] && wb_req_i.dat[STAT_FUP_BIT]) s_d.freq_update_flag = 1'b0;
            end
            OFS_COMMAND: begin
               if (wb_req_i.dat == CMD_STANDBY) begin
                  s_d.pwr = EMC_STANDBY;  // [RULE3]
                  s_d.adc_pd = 3'h7;  // [RULE3]
                  s_d.buf_pd = 1'b1;
                  s_d.temp_pd = 1'b1;
                  s_d.data_ready_flag = 1'b1;  // [RULE5]
               end else if (wb_req_i.dat == CMD_WAKEUP) begin
                  s_d.pwr = EMC_RUN;  // [RULE4]
                  s_d.adc_pd = 3'h0;  // [RULE4]
                  s_d.buf_pd = 1'b0;
                  s_d.temp_pd = 1'b0;
                  s_d.data_ready_flag = 1'b1;  // [RULE5]
               end
            end
            OFS_VZX_THRESH: begin
               wdat = emc_merge({8'h0, s_q.vzx_th}, wb_req_i.dat, wb_req_i.sel);
               s_d.vzx_th = wdat[23:0];
            end
            OFS_IZX_THRESH: begin
               wdat = emc_merge({8'h0, s_q.izx_th}, wb_req_i.dat, wb_req_i.sel);
               s_d.izx_th = wdat[23:0];
            end
            OFS_CROSS_COUNT: begin
               wdat = emc_merge({16'h0, s_q.crossing_count_setting}, wb_req_i.dat, wb_req_i.sel);
               s_d.crossing_count_setting = wdat[15:0];
            end
            OFS_FREQ_RATIO: begin
               wdat = emc_merge({8'h0, s_q.eps}, wb_req_i.dat, wb_req_i.sel);
               s_d.eps = wdat[23:0];
            end
            OFS_MIN_SWITCH: s_d.min_amp = emc_merge(s_q.min_amp, wb_req_i.dat, wb_req_i.sel);
            OFS_CHAN_LEVEL: begin
               wdat = emc_merge({8'h0, s_q.lvl}, wb_req_i.dat, wb_req_i.sel);
               s_d.lvl = wdat[23:0];
            end
            OFS_FIXED_VOLT: begin
               wdat = emc_merge({8'h0, s_q.fixed_voltage_enable_val}, wb_req_i.dat, wb_req_i.sel);
               s_d.fixed_voltage_enable_val = wdat[23:0];
            end
            default: s_d.ack = s_d.ack;
         endcase
      end

      // Crossing detection
      if (samples_i.tick && run) begin
         s_d.v_f = v_lp[23:0];  // [RULE7]
         s_d.i_f = i_lp[23:0];  // [RULE7]
         s_d.v_sgn = v_det[23];
         s_d.i_sgn = i_det[23];
         s_d.zx_v = v_cross;
         s_d.zx_i = i_cross;
         // Frequency measurement
         if (s_q.cfg2[CFG2_AFC_BIT] && !s_q.busy) begin  // [RULE9]
            s_d.ticks = s_q.ticks + 32'h00000001;
            if (v_cross) begin
               if (!s_q.armed) begin
                  s_d.armed = 1'b1;
                  s_d.ticks = 32'h00000000;
                  s_d.zx_cnt = 16'h0000;
               end else if (s_q.zx_cnt + 16'h0001 >= s_q.crossing_count_setting) begin  // [RULE10]
                  s_d.busy = 1'b1;
                  s_d.step = 5'h00;
                  s_d.rem = {17'h00000, s_q.crossing_count_setting};
                  s_d.den = s_q.ticks + 32'h00000001;
                  s_d.quo = 24'h000000;
                  s_d.ticks = 32'h00000000;
                  s_d.zx_cnt = 16'h0000;
               end else begin
                  s_d.zx_cnt = s_q.zx_cnt + 16'h0001;
               end
            end
         end else if (!s_q.cfg2[CFG2_AFC_BIT]) begin
            s_d.armed = 1'b0;
         end
      end

      // Ratio = crossings / (2 * ticks); valid only for 40..75 Hz lines  [RULE12]
      if (s_q.busy) begin
         rem2 = {s_q.rem[31:0], 1'b0};
         if (rem2 >= {1'b0, s_q.den}) begin
            s_d.rem = 33'(rem2 - {1'b0, s_q.den});
            s_d.quo = {s_q.quo[22:0], 1'b1};
         end else begin
            s_d.rem = rem2;
            s_d.quo = {s_q.quo[22:0], 1'b0};
         end
         s_d.step = s_q.step + 5'h01;
         if (s_q.step == 5'(DIV_STEPS - 1)) begin
            s_d.busy = 1'b0;
            s_d.eps = {s_q.quo[22:0], rem2 >= {1'b0, s_q.den}};  // [RULE11] [RULE13]
            s_d.freq_update_flag = 1'b1;  // [RULE11]
         end
      end

      // Low-rate evaluation
      if (lowrate_i.done && run) begin  // [RULE22]
         if (s_q.cfg2[CFG2_HOLD_BIT]) begin
            s_d.chan = s_q.cfg2[CFG2_FORCE_BIT];  // [RULE19]
         end else if (m1 > s_q.min_amp || m2 > s_q.min_amp) begin  // [RULE17]
            if (oth_scaled > act_scaled) begin  // [RULE18]
               s_d.chan = ~s_q.chan;  // [RULE16]
            end
         end
         if (s_q.cfg2[CFG2_MODE_LO +: 2] == MODE_DUAL) begin
            s_d.tot.p = emc_half_sum(lowrate_i.ch1.p_avg, lowrate_i.ch2.p_avg);  // [RULE14]
            s_d.tot.q = emc_half_sum(lowrate_i.ch1.q_avg, lowrate_i.ch2.q_avg);  // [RULE14]
            s_d.tot.s = emc_half_sum(lowrate_i.ch1.s_avg, lowrate_i.ch2.s_avg);  // [RULE14]
         end else if (s_d.chan) begin
            s_d.tot = {lowrate_i.ch2.p_avg, lowrate_i.ch2.q_avg, lowrate_i.ch2.s_avg};  // [RULE15]
         end else begin
            s_d.tot = {lowrate_i.ch1.p_avg, lowrate_i.ch1.q_avg, lowrate_i.ch1.s_avg};  // [RULE15]
         end
      end

      // Voltage feeding the power paths
      s_d.v_act = s_q.cfg2[CFG2_FIXED_VOLTAGE_ENABLE_BIT] ? s_q.fixed_voltage_enable_val : samples_i.v_rms;  // [RULE20]
      s_d.v_react = samples_i.v_rms;  // [RULE21]
   end

   // ---------------------------------------------------------------
   // Datapath helpers
   // ---------------------------------------------------------------
   always_comb begin
      i_smp = s_q.cfg0_izx ? samples_i.i2 : samples_i.i1;  // [RULE6]
      i_pk = s_q.cfg0_izx ? samples_i.i2_peak : samples_i.i1_peak;  // [RULE6]
      v_lp = {s_q.v_f[23], s_q.v_f}
         + 25'($signed({samples_i.v[23], samples_i.v} - {s_q.v_f[23], s_q.v_f}) >>> LPF_SHIFT);
      i_lp = {s_q.i_f[23], s_q.i_f} + 25'($signed({i_smp[23], i_smp} - {s_q.i_f[23], s_q.i_f}) >>> LPF_SHIFT);
      v_det = s_q.cfg2[CFG2_LPF_BIT] ? v_lp[23:0] : samples_i.v;  // [RULE7]
      i_det = s_q.cfg2[CFG2_LPF_BIT] ? i_lp[23:0] : i_smp;  // [RULE7]
      v_cross = (v_det[23] != s_q.v_sgn) && (samples_i.v_peak > s_q.vzx_th);  // [RULE8]
      i_cross = (i_det[23] != s_q.i_sgn) && (i_pk > s_q.izx_th);  // [RULE8]
      m1 = s_q.cfg2[CFG2_BASIS_BIT] ? {8'h00, lowrate_i.ch1.i_rms} : emc_abs(lowrate_i.ch1.p_avg);  // [RULE16]
      m2 = s_q.cfg2[CFG2_BASIS_BIT] ? {8'h00, lowrate_i.ch2.i_rms} : emc_abs(lowrate_i.ch2.p_avg);  // [RULE16]
      act_scaled = 56'(s_q.chan ? m2 : m1) * 56'(s_q.lvl);  // [RULE18]
      oth_scaled = {1'b0, (s_q.chan ? m1 : m2), 23'h000000};
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_q <= '0;
         s_q.mrst <= 1'b1;
         s_q.pwr <= EMC_RUN;
         s_q.crossing_count_setting <= RST_CROSS_COUNT;  // [RULE10]
         s_q.eps <= RST_FREQ_RATIO;  // [RULE13]
         s_q.lvl <= RST_CHAN_LEVEL;
         s_q.fixed_voltage_enable_val <= RST_FIXED_VOLT;  // [RULE20]
      end else begin
         s_q <= s_d;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign wb_rsp_o = '{ack: s_q.ack, dat: s_q.rdat};
   assign master_rst_o = s_q.mrst;
   assign power_o = '{adc_pd: s_q.adc_pd, buf_pd: s_q.buf_pd, temp_pd: s_q.temp_pd, sys_run: run};
   assign zx_voltage_o = s_q.zx_v;
   assign zx_current_o = s_q.zx_i;
   assign freq_ratio_o = s_q.eps;
   assign chan_sel_o = s_q.chan;
   assign totals_o = s_q.tot;
   assign v_active_o = s_q.v_act;
   assign v_reactive_o = s_q.v_react;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   logic [22:0] good_run_q;
   logic cmd_wr;
   always_ff @(posedge clk_i) begin
      if (rst_i || !por_good) begin
         good_run_q <= '0;
      end else if (good_run_q != '1) begin
         good_run_q <= good_run_q + 23'h000001;
      end
   end
   assign cmd_wr = wb_wr && (wb_req_i.adr == OFS_COMMAND);

   default clocking emc_cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   chk_por_and_gate: assert property (!(por_fine_analog_i && por_fine_digital_i) |=> master_rst_o)  // [RULE2]
      else $error("master reset not asserted after supply drop");
   chk_reset_hold_len: assert property ($fell(master_rst_o) |-> good_run_q == 23'(MASTER_RST_CYCLES))  // [RULE1]
      else $error("master reset released after wrong hold time");
   chk_standby_pd: assert property (cmd_wr && wb_req_i.dat == CMD_STANDBY  // [RULE3]
      |=> power_o.adc_pd == 3'h7 && !power_o.sys_run && power_o.buf_pd && power_o.temp_pd)
      else $error("standby did not power down");
   chk_wake_clear: assert property (cmd_wr && wb_req_i.dat == CMD_WAKEUP  // [RULE4]
      |=> power_o.adc_pd == 3'h0 && power_o.sys_run)
      else $error("wake-up did not restore power");
   chk_cmd_data_ready_flag: assert property (cmd_wr && (wb_req_i.dat == CMD_STANDBY || wb_req_i.dat == CMD_WAKEUP)  // [RULE5]
      |=> s_q.data_ready_flag)
      else $error("data-ready not set after command");
   chk_fup_ratio: assert property (s_q.busy && s_q.step == 5'(DIV_STEPS - 1)  // [RULE11]
      |=> s_q.freq_update_flag && $changed(s_q.busy))
      else $error("frequency update flag missing");
   chk_afc_gate: assert property (!s_q.cfg2[CFG2_AFC_BIT] && !s_q.busy |=> !s_q.busy)  // [RULE9]
      else $error("frequency measurement ran while disabled");
   chk_zx_thresh: assert property (zx_voltage_o |-> $past(samples_i.v_peak) > $past(s_q.vzx_th))  // [RULE8]
      else $error("voltage crossing below threshold");
   chk_dual_average: assert property (lowrate_i.done && run && s_q.cfg2[CFG2_MODE_LO +: 2] == MODE_DUAL  // [RULE14]
      |=> totals_o.p == emc_half_sum($past(lowrate_i.ch1.p_avg), $past(lowrate_i.ch2.p_avg)))
      else $error("dual mode total is not half the sum");
   chk_hold_force: assert property (lowrate_i.done && run && s_q.cfg2[CFG2_HOLD_BIT]  // [RULE19]
      |=> chan_sel_o == $past(s_q.cfg2[CFG2_FORCE_BIT]))
      else $error("held selection ignores force bit");
   chk_fixed_volt: assert property (s_q.cfg2[CFG2_FIXED_VOLTAGE_ENABLE_BIT] |=> v_active_o == $past(s_q.fixed_voltage_enable_val))  // [RULE20]
      else $error("fixed voltage not applied to active path");
   chk_reactive_volt: assert property (##1 v_reactive_o == $past(samples_i.v_rms))  // [RULE21]
      else $error("reactive path voltage altered");

   cov_standby: cover property (cmd_wr && wb_req_i.dat == CMD_STANDBY);
   cov_freq_done: cover property ($rose(s_q.freq_update_flag));
   cov_chan_switch: cover property ($changed(chan_sel_o) && !s_q.cfg2[CFG2_HOLD_BIT]);
endmodule : emc_core
`default_nettype wire

// ---- logic/emc_pkg.sv ----
// Purpose: Shared types and constants for the energy meter channel control block
// Assumes: 25 MHz clock, output word rate 4000 Hz, classic Wishbone slave with 32-bit data
// Notes:   Fractions are unsigned fixed point; Q0.24 unless stated
package emc_pkg;
   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int unsigned CLK_HZ = 25_000_000;
   localparam int unsigned RST_HOLD_MS = 130;
   localparam int unsigned RST_HOLD_CYCLES = RST_HOLD_MS * (CLK_HZ / 1000);
   localparam int unsigned OWR_HZ = 4000;
   localparam int unsigned LPF_CUTOFF_HZ = 80;
   // Shift of 3 gives a pole near 2*pi*80/4000
   localparam int unsigned LPF_SHIFT = 3;
   localparam int unsigned DIV_STEPS = 23;
   // ---------------------------------------------------------------
   // Register offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] OFS_FIRST_CFG = 8'h00;
   localparam logic [7:0] OFS_SECOND_CFG = 8'h04;
   localparam logic [7:0] OFS_PRIMARY_STATUS = 8'h08;
   localparam logic [7:0] OFS_COMMAND = 8'h0C;
   localparam logic [7:0] OFS_VZX_THRESH = 8'h10;
   localparam logic [7:0] OFS_IZX_THRESH = 8'h14;
   localparam logic [7:0] OFS_CROSS_COUNT = 8'h18;
   localparam logic [7:0] OFS_FREQ_RATIO = 8'h1C;
   localparam logic [7:0] OFS_MIN_SWITCH = 8'h20;
   localparam logic [7:0] OFS_CHAN_LEVEL = 8'h24;
   localparam logic [7:0] OFS_FIXED_VOLT = 8'h28;
   localparam logic [7:0] OFS_P_TOTAL = 8'h2C;
   localparam logic [7:0] OFS_Q_TOTAL = 8'h30;
   localparam logic [7:0] OFS_S_TOTAL = 8'h34;
   // ---------------------------------------------------------------
   // Fields
   // ---------------------------------------------------------------
   localparam int unsigned CFG0_IZX_BIT = 0;
   localparam int unsigned CFG2_MODE_LO = 0;
   localparam int unsigned CFG2_LPF_BIT = 2;
   localparam int unsigned CFG2_AFC_BIT = 3;
   localparam int unsigned CFG2_BASIS_BIT = 4;
   localparam int unsigned CFG2_HOLD_BIT = 5;
   localparam int unsigned CFG2_FORCE_BIT = 6;
   localparam int unsigned CFG2_FIXED_VOLTAGE_ENABLE_BIT = 7;
   localparam int unsigned STAT_DATA_READY_FLAG_BIT = 0;
   localparam int unsigned STAT_FUP_BIT = 1;
   localparam int unsigned STAT_CHAN_BIT = 8;
   localparam int unsigned STAT_STBY_BIT = 9;
   localparam logic [1:0] MODE_SINGLE = 2'h0;
   localparam logic [1:0] MODE_DUAL = 2'h1;
   localparam logic [31:0] CMD_STANDBY = 32'h00000001;
   localparam logic [31:0] CMD_WAKEUP = 32'h00000002;
   localparam int unsigned LEVEL_FRAC = 23;
   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [15:0] RST_CROSS_COUNT = 16'h0064;
   localparam logic [23:0] RST_FREQ_RATIO = 24'h033333;
   localparam logic [23:0] RST_FIXED_VOLT = 24'hB504F3;
   localparam logic [23:0] RST_CHAN_LEVEL = 24'h828F5C;
   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic {EMC_RUN, EMC_STANDBY} emc_pwr_t;
   typedef struct packed {logic cyc; logic stb; logic we; logic [7:0] adr;
                          logic [3:0] sel; logic [31:0] dat;} emc_wb_req_t;
   typedef struct packed {logic ack; logic [31:0] dat;} emc_wb_rsp_t;
   typedef struct packed {logic tick; logic [23:0] v; logic [23:0] i1; logic [23:0] i2;
                          logic [23:0] v_peak; logic [23:0] i1_peak; logic [23:0] i2_peak; logic [23:0] v_rms;} emc_samples_t;
   typedef struct packed {logic [31:0] p_avg; logic [31:0] q_avg; logic [31:0] s_avg; logic [23:0] i_rms;} emc_chan_t;
   typedef struct packed {logic done; emc_chan_t ch1; emc_chan_t ch2;} emc_lowrate_t;
   typedef struct packed {logic [2:0] adc_pd; logic buf_pd; logic temp_pd; logic sys_run;} emc_power_t;
   typedef struct packed {logic [31:0] p; logic [31:0] q; logic [31:0] s;} emc_totals_t;
endpackage : emc_pkg
